// file: ddr_cap_pkg.sv
`default_nettype none
package ddr_cap_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W     = 22;
  localparam int BANK_W     = 3;
  localparam int LANE_W     = 18;
  localparam int LANES      = 2;
  localparam int DATA_W     = LANE_W * LANES;
  localparam int NARROW_W   = 9;

  // ---------------------------------------------------------------
  // timing counts
  // ---------------------------------------------------------------
  // system cycles an accepted operation keeps the array busy
  localparam int OP_CYCLES  = 4;
  localparam int CNT_W      = 4;

  // ---------------------------------------------------------------
  // command encoding on {we_n, ref_n} while chip select is low
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_MODE_SET = 2'h0,
    CMD_REFRESH  = 2'h1,
    CMD_WRITE    = 2'h2,
    CMD_READ     = 2'h3
  } cmd_t;

  // ---------------------------------------------------------------
  // data width configuration strap
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    WIDTH_X9  = 2'h0,
    WIDTH_X18 = 2'h1,
    WIDTH_X36 = 2'h2
  } width_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'h0,
    ST_BUSY = 1'h1
  } op_state_t;

  // ---------------------------------------------------------------
  // drop and select levels, keep masks
  // ---------------------------------------------------------------
  localparam logic MASK_DROP        = 1'h1;
  localparam logic CS_SELECT        = 1'h0;
  localparam logic [LANE_W-1:0] KEEP_X9  = 18'h001FF;
  localparam logic [LANE_W-1:0] KEEP_ALL = 18'h3FFFF;

endpackage

`default_nettype wire

// file: lane_if.sv
`timescale 1ns/10ps
`default_nettype none

// one captured beat pair of a write data lane, held for a whole
// data clock period and announced by a toggle
interface lane_if;
  logic [ddr_cap_pkg::LANE_W-1:0] rise_data;
  logic [ddr_cap_pkg::LANE_W-1:0] fall_data;
  logic                           rise_mask;
  logic                           fall_mask;
  logic                           pair_toggle;

  modport capture (output rise_data, fall_data, rise_mask, fall_mask, pair_toggle);
  modport sink    (input  rise_data, fall_data, rise_mask, fall_mask, pair_toggle);
endinterface

`default_nettype wire

// file: wr_lane_capture.sv
`timescale 1ns/10ps
`default_nettype none

module wr_lane_capture (
  // data clock of this lane
  input  wire logic                           i_dclk,
  input  wire logic                           i_arst_n,
  // write data pins
  input  wire logic [ddr_cap_pkg::LANE_W-1:0] i_dq,
  input  wire logic                           i_mask,
  // captured pairs
  lane_if.capture                             lane
);

  logic [ddr_cap_pkg::LANE_W-1:0] rise_beat_reg;
  logic                           rise_mask_reg;
  logic [ddr_cap_pkg::LANE_W-1:0] pair_rise_reg;
  logic [ddr_cap_pkg::LANE_W-1:0] pair_fall_reg;
  logic                           pair_rmask_reg;
  logic                           pair_fmask_reg;
  logic                           toggle_reg;

  // ---------------------------------------------------------------
  // rising edge beat
  // ---------------------------------------------------------------
  always_ff @(posedge i_dclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rise_beat_reg <= '0;
      rise_mask_reg <= 1'h0;
    end else begin
      rise_beat_reg <= i_dq;
      rise_mask_reg <= i_mask;
    end
  end

  // ---------------------------------------------------------------
  // falling edge beat closes the pair
  // ---------------------------------------------------------------
  // the pair stays put for one whole data clock period, which is
  // what lets the system side read it after the toggle crossing
  always_ff @(negedge i_dclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pair_rise_reg  <= '0;
      pair_fall_reg  <= '0;
      pair_rmask_reg <= 1'h0;
      pair_fmask_reg <= 1'h0;
      toggle_reg     <= 1'h0;
    end else begin
      pair_rise_reg  <= rise_beat_reg;
      pair_fall_reg  <= i_dq;
      pair_rmask_reg <= rise_mask_reg;
      pair_fmask_reg <= i_mask;
      toggle_reg     <= ~toggle_reg;
    end
  end

  assign lane.rise_data   = pair_rise_reg;
  assign lane.fall_data   = pair_fall_reg;
  assign lane.rise_mask   = pair_rmask_reg;
  assign lane.fall_mask   = pair_fmask_reg;
  assign lane.pair_toggle = toggle_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_fall_beat;
    @(negedge i_dclk) disable iff (!i_arst_n)
      1'b1 |=> (lane.fall_data == $past(i_dq)) && (lane.fall_mask == $past(i_mask));
  endproperty
  a_fall_beat: assert property (p_fall_beat) else $error("fall beat not captured");

  property p_rise_beat;
    @(posedge i_dclk) disable iff (!i_arst_n)
      1'b1 ##1 1'b1 |-> ##1 (lane.rise_data == $past(i_dq));
  endproperty
  a_rise_beat: assert property (p_rise_beat) else $error("rise beat not paired");

endmodule // wr_lane_capture

`default_nettype wire

// file: ddr_mem_input_capture.sv
`timescale 1ns/10ps
`default_nettype none

module ddr_mem_input_capture #(
  parameter int OP_CYCLES = ddr_cap_pkg::OP_CYCLES
) (
  // clocks and reset
  input  wire logic                                I_CLK_SYS,
  input  wire logic                                I_ARST_N,
  input  wire logic                                I_MAIN_CLK_TRUE,
  input  wire logic                                I_WR_DATA_CLK_LO_LANE,
  input  wire logic                                I_WR_DATA_CLK_HI_LANE,
  // command pins
  input  wire logic                                I_CS_N,
  input  wire logic                                I_WE_N,
  input  wire logic                                I_REF_N,
  input  wire logic [ddr_cap_pkg::ADDR_W-1:0]      I_ADDR_IN,
  input  wire logic [ddr_cap_pkg::BANK_W-1:0]      I_BANK_SELECT,
  // write data pins
  input  wire logic [ddr_cap_pkg::DATA_W-1:0]      I_DQ,
  input  wire logic                                I_WRITE_BYTE_MASK,
  // straps
  input  wire logic [1:0]                          I_WIDTH_CFG,
  input  wire logic                                I_ON_DIE_TERMINATION,
  input  wire logic                                I_LATER_DIE_REV,
  // decoded commands
  output logic                                     O_CMD_VALID,
  output logic [1:0]                               O_CMD,
  output logic [ddr_cap_pkg::ADDR_W-1:0]           O_ADDR,
  output logic [ddr_cap_pkg::BANK_W-1:0]           O_BANK,
  output logic                                     O_MODE_LOAD,
  output logic [ddr_cap_pkg::ADDR_W-1:0]           O_MODE_VALUE,
  output logic                                     O_OP_BUSY,
  // write beats
  output wire logic [ddr_cap_pkg::DATA_W-1:0]      O_WR_DATA_RISE,
  output wire logic [ddr_cap_pkg::DATA_W-1:0]      O_WR_DATA_FALL,
  output wire logic [ddr_cap_pkg::LANES-1:0]       O_WR_RISE_VALID,
  output wire logic [ddr_cap_pkg::LANES-1:0]       O_WR_FALL_VALID,
  // unused io balls
  output logic                                     O_UNUSED_IO_BALL_O,
  output logic                                     O_UNUSED_IO_BALL_OE,
  output logic                                     O_UNUSED_IO_BALL_TERM
);

  // ---------------------------------------------------------------
  // link side: command pins on the main clock
  // ---------------------------------------------------------------
  logic                             cmd_toggle_reg;
  logic [ddr_cap_pkg::ADDR_W-1:0]   addr_hold_reg;
  logic [ddr_cap_pkg::BANK_W-1:0]   bank_hold_reg;
  logic [1:0]                       code_hold_reg;
  wire  logic                       decoder_on = (I_CS_N == ddr_cap_pkg::CS_SELECT);

  // only the true phase clocks this; the complement is not used
  always_ff @(posedge I_MAIN_CLK_TRUE or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cmd_toggle_reg <= 1'h0;
      addr_hold_reg  <= '0;
      bank_hold_reg  <= '0;
      code_hold_reg  <= 2'h3;
    end else if (decoder_on) begin
      cmd_toggle_reg <= ~cmd_toggle_reg;
      addr_hold_reg  <= I_ADDR_IN;
      bank_hold_reg  <= I_BANK_SELECT;
      code_hold_reg  <= {I_WE_N, I_REF_N};
    end
  end

  // ---------------------------------------------------------------
  // crossing into the system clock
  // ---------------------------------------------------------------
  // the held word changes at most once per main clock period, far
  // longer than the three system edges the toggle needs to arrive
  logic cmd_s1_reg;
  logic cmd_s2_reg;
  logic cmd_s3_reg;

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cmd_s1_reg <= 1'h0;
      cmd_s2_reg <= 1'h0;
      cmd_s3_reg <= 1'h0;
    end else begin
      cmd_s1_reg <= cmd_toggle_reg;
      cmd_s2_reg <= cmd_s1_reg;
      cmd_s3_reg <= cmd_s2_reg;
    end
  end

  wire logic              cmd_event = cmd_s2_reg ^ cmd_s3_reg;
  wire ddr_cap_pkg::cmd_t cmd_kind  = ddr_cap_pkg::cmd_t'(code_hold_reg);
  wire logic              is_mode   = (cmd_kind == ddr_cap_pkg::CMD_MODE_SET);
  wire logic              is_access = (cmd_kind == ddr_cap_pkg::CMD_READ) ||
                                      (cmd_kind == ddr_cap_pkg::CMD_WRITE);

  // ---------------------------------------------------------------
  // strap synchronisers
  // ---------------------------------------------------------------
  logic [3:0] strap_s1_reg;
  logic [3:0] strap_s2_reg;

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      strap_s1_reg <= 4'h0;
      strap_s2_reg <= 4'h0;
    end else begin
      strap_s1_reg <= {I_LATER_DIE_REV, I_ON_DIE_TERMINATION, I_WIDTH_CFG};
      strap_s2_reg <= strap_s1_reg;
    end
  end

  wire ddr_cap_pkg::width_t width_q = ddr_cap_pkg::width_t'(strap_s2_reg[1:0]);
  wire logic                term_q  = strap_s2_reg[2];
  wire logic                later_q = strap_s2_reg[3];
  wire logic                wide    = (width_q == ddr_cap_pkg::WIDTH_X36);

  // ---------------------------------------------------------------
  // decoded command outputs
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_CMD_VALID  <= 1'h0;
      O_CMD        <= 2'h3;
      O_ADDR       <= '0;
      O_BANK       <= '0;
      O_MODE_LOAD  <= 1'h0;
      O_MODE_VALUE <= '0;
    end else begin
      O_CMD_VALID <= cmd_event;
      O_MODE_LOAD <= cmd_event && is_mode;
      if (cmd_event) begin
        O_CMD  <= code_hold_reg;
        O_BANK <= bank_hold_reg;
      end
      if (cmd_event && is_access) begin
        O_ADDR <= addr_hold_reg;
      end
      if (cmd_event && is_mode) begin
        O_MODE_VALUE <= addr_hold_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // internal operation: runs to the end whatever chip select does
  // ---------------------------------------------------------------
  ddr_cap_pkg::op_state_t        op_state_reg;
  ddr_cap_pkg::op_state_t        op_state_next;
  logic [ddr_cap_pkg::CNT_W-1:0] op_cnt_reg;
  logic [ddr_cap_pkg::CNT_W-1:0] op_cnt_next;
  wire  logic                    op_start = cmd_event && !is_mode;

  always_comb begin
    op_state_next = op_state_reg;
    op_cnt_next   = op_cnt_reg;
    case (op_state_reg)
      ddr_cap_pkg::ST_IDLE: begin
        if (op_start) begin
          op_state_next = ddr_cap_pkg::ST_BUSY;
          op_cnt_next   = ddr_cap_pkg::CNT_W'(OP_CYCLES - 1);
        end
      end
      ddr_cap_pkg::ST_BUSY: begin
        if (op_start) begin
          op_cnt_next = ddr_cap_pkg::CNT_W'(OP_CYCLES - 1);
        end else if (op_cnt_reg == '0) begin
          op_state_next = ddr_cap_pkg::ST_IDLE;
        end else begin
          op_cnt_next = op_cnt_reg - 1'b1;
        end
      end
      default: begin
        op_state_next = ddr_cap_pkg::ST_IDLE;
        op_cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      op_state_reg <= ddr_cap_pkg::ST_IDLE;
      op_cnt_reg   <= '0;
    end else begin
      op_state_reg <= op_state_next;
      op_cnt_reg   <= op_cnt_next;
    end
  end

  assign O_OP_BUSY = (op_state_reg == ddr_cap_pkg::ST_BUSY);

  // ---------------------------------------------------------------
  // write data lanes
  // ---------------------------------------------------------------
  // lane 1 is clocked even in the narrow widths; a stopped high lane
  // clock would only freeze its unused pairs, never lane 0
  wire logic [ddr_cap_pkg::LANES-1:0] lane_clk = {I_WR_DATA_CLK_HI_LANE, I_WR_DATA_CLK_LO_LANE};
  wire logic [ddr_cap_pkg::LANE_W-1:0] keep_lo =
    (width_q == ddr_cap_pkg::WIDTH_X9) ? ddr_cap_pkg::KEEP_X9 : ddr_cap_pkg::KEEP_ALL;

  lane_if lanes[ddr_cap_pkg::LANES] ();

  genvar g;
  generate
    for (g = 0; g < ddr_cap_pkg::LANES; g = g + 1) begin : g_lane
      logic                           t1_reg;
      logic                           t2_reg;
      logic                           t3_reg;
      logic [ddr_cap_pkg::LANE_W-1:0] rise_reg;
      logic [ddr_cap_pkg::LANE_W-1:0] fall_reg;
      logic                           rvld_reg;
      logic                           fvld_reg;
      wire  logic                     pair_event = t2_reg ^ t3_reg;
      // lane 0 serves every width, lane 1 only the widest one
      wire  logic                     lane_on = (g == 0) || wide;
      wire  logic [ddr_cap_pkg::LANE_W-1:0] keep = (g == 0) ? keep_lo : ddr_cap_pkg::KEEP_ALL;

      wr_lane_capture u_capture (
        .i_dclk   (lane_clk[g]),
        .i_arst_n (I_ARST_N),
        .i_dq     (I_DQ[g*ddr_cap_pkg::LANE_W +: ddr_cap_pkg::LANE_W]),
        .i_mask   (I_WRITE_BYTE_MASK),
        .lane     (lanes[g].capture)
      );

      always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
          t1_reg <= 1'h0;
          t2_reg <= 1'h0;
          t3_reg <= 1'h0;
        end else begin
          t1_reg <= lanes[g].pair_toggle;
          t2_reg <= t1_reg;
          t3_reg <= t2_reg;
        end
      end

      always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
          rise_reg <= '0;
          fall_reg <= '0;
          rvld_reg <= 1'h0;
          fvld_reg <= 1'h0;
        end else begin
          rvld_reg <= pair_event && lane_on && (lanes[g].rise_mask != ddr_cap_pkg::MASK_DROP);
          fvld_reg <= pair_event && lane_on && (lanes[g].fall_mask != ddr_cap_pkg::MASK_DROP);
          if (pair_event && lane_on) begin
            rise_reg <= lanes[g].rise_data & keep;
            fall_reg <= lanes[g].fall_data & keep;
          end
        end
      end

      assign O_WR_DATA_RISE[g*ddr_cap_pkg::LANE_W +: ddr_cap_pkg::LANE_W] = rise_reg;
      assign O_WR_DATA_FALL[g*ddr_cap_pkg::LANE_W +: ddr_cap_pkg::LANE_W] = fall_reg;
      assign O_WR_RISE_VALID[g] = rvld_reg;
      assign O_WR_FALL_VALID[g] = fvld_reg;
    end
  endgenerate

  // ---------------------------------------------------------------
  // unused io balls under termination
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_UNUSED_IO_BALL_O    <= 1'h0;
      O_UNUSED_IO_BALL_OE   <= 1'h0;
      O_UNUSED_IO_BALL_TERM <= 1'h0;
    end else begin
      O_UNUSED_IO_BALL_O    <= 1'h0;
      O_UNUSED_IO_BALL_OE   <= 1'h0;
      O_UNUSED_IO_BALL_TERM <= term_q && !later_q;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_deselect_ignored;
    @(posedge I_MAIN_CLK_TRUE) disable iff (!I_ARST_N)
      I_CS_N |=> $stable(cmd_toggle_reg) && $stable(addr_hold_reg);
  endproperty
  a_deselect_ignored: assert property (p_deselect_ignored) else $error("command taken while deselected");

  property p_select_latch;
    @(posedge I_MAIN_CLK_TRUE) disable iff (!I_ARST_N)
      !I_CS_N |=> (cmd_toggle_reg != $past(cmd_toggle_reg)) && (addr_hold_reg == $past(I_ADDR_IN))
                  && (code_hold_reg == $past({I_WE_N, I_REF_N}));
  endproperty
  a_select_latch: assert property (p_select_latch) else $error("selected command not latched");

  property p_bank_route;
    @(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      cmd_event |=> O_CMD_VALID && (O_BANK == $past(bank_hold_reg)) && (O_CMD == $past(code_hold_reg));
  endproperty
  a_bank_route: assert property (p_bank_route) else $error("bank or command not forwarded");

  property p_access_addr;
    @(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      cmd_event && is_access |=> (O_ADDR == $past(addr_hold_reg)) && !O_MODE_LOAD;
  endproperty
  a_access_addr: assert property (p_access_addr) else $error("access address wrong");

  property p_mode_set;
    @(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      cmd_event && is_mode |=> O_MODE_LOAD && (O_MODE_VALUE == $past(addr_hold_reg)) && $stable(O_ADDR);
  endproperty
  a_mode_set: assert property (p_mode_set) else $error("mode set not loaded");

  property p_op_runs;
    @(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      op_start |=> O_OP_BUSY [*4];
  endproperty
  a_op_runs: assert property (p_op_runs) else $error("operation cut short");

  property p_narrow_lane;
    @(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      !wide |=> !O_WR_RISE_VALID[1] && !O_WR_FALL_VALID[1];
  endproperty
  a_narrow_lane: assert property (p_narrow_lane) else $error("high lane used in narrow width");

  property p_wide_lane;
    @(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      wide && g_lane[1].pair_event && !lanes[1].fall_mask |=>
        O_WR_FALL_VALID[1] && (O_WR_DATA_FALL[35:18] == $past(lanes[1].fall_data));
  endproperty
  a_wide_lane: assert property (p_wide_lane) else $error("high lane beat lost");

  property p_mask_drop;
    @(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      g_lane[0].pair_event && lanes[0].rise_mask |=> !O_WR_RISE_VALID[0];
  endproperty
  a_mask_drop: assert property (p_mask_drop) else $error("masked beat passed");

  property p_unused_ball;
    @(posedge I_CLK_SYS) disable iff (!I_ARST_N)
      term_q ##1 $stable(term_q) && $stable(later_q) |->
        (O_UNUSED_IO_BALL_TERM == !later_q) && !O_UNUSED_IO_BALL_OE;
  endproperty
  a_unused_ball: assert property (p_unused_ball) else $error("unused ball state wrong");

  c_mode_set:   cover property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N) O_MODE_LOAD);
  c_wide_write: cover property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N) &O_WR_FALL_VALID);
  c_masked:     cover property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N)
                                g_lane[0].pair_event && lanes[0].rise_mask);
  c_back2back:  cover property (@(posedge I_CLK_SYS) disable iff (!I_ARST_N) op_start && O_OP_BUSY);

endmodule // ddr_mem_input_capture

`default_nettype wire

// file: ctl_model.sv
`timescale 1ns/10ps
`default_nettype none

module ctl_model (
  // main clock and command pins
  output logic        o_main_clk,
  output logic        o_cs_n,
  output logic [1:0]  o_cmd,
  output logic [21:0] o_addr,
  output logic [2:0]  o_bank,
  // write data pins
  output logic        o_data_clk,
  output logic [35:0] o_dq,
  output logic        o_byte_mask
);
  logic        c_pend = 1'h0;
  logic [27:0] c_val;
  logic        d_pend = 1'h0;
  logic        d_take;
  logic [71:0] d_val;
  logic [1:0]  d_mask;

  // -------------------------------------------------------------
  // free running clocks; idle lines show the inverse of last value, except chip select and byte mask, which are held high
  // -------------------------------------------------------------
  initial begin
    {o_main_clk, o_cs_n, o_cmd, o_addr, o_bank} = {2'h1, 27'h0};
    #1.3;
    forever begin
      if (c_pend) begin
        {o_cs_n, o_cmd, o_addr, o_bank} = c_val;
      end else begin
        {o_cs_n, o_cmd, o_addr, o_bank} = {1'h1, ~o_cmd, ~o_addr, ~o_bank};
      end
      c_pend = 1'h0;
      #16 o_main_clk = 1'h1;
      #16 o_main_clk = 1'h0;
    end
  end

  // idle pairs are masked, so only requested pairs may be taken
  initial begin
    {o_data_clk, o_dq, o_byte_mask} = {37'h0, 1'h1};
    #2.7;
    forever begin
      d_take = d_pend;
      d_pend = 1'h0;
      o_dq = d_take ? d_val[71:36] : ~o_dq;
      o_byte_mask = d_take ? d_mask[1] : 1'h1;
      #8 o_data_clk = 1'h1;
      #8 o_dq = d_take ? d_val[35:0] : ~o_dq;
      o_byte_mask = d_take ? d_mask[0] : 1'h1;
      #8 o_data_clk = 1'h0;
      #8;
    end
  end

  task automatic cmd(input logic [27:0] v);
    c_val = v;
    c_pend = 1'h1;
    wait (!c_pend);
  endtask

  task automatic pair(input logic [71:0] v, input logic [1:0] m);
    {d_val, d_mask} = {v, m};
    d_pend = 1'h1;
    wait (!d_pend);
  endtask
endmodule // ctl_model

`default_nettype wire

// file: ddr_mem_input_capture_bench.sv
`timescale 1ns/10ps
`default_nettype none

module ddr_mem_input_capture_bench;
  localparam int OPC = 4;
  logic        I_CLK_SYS, I_ARST_N, I_ON_DIE_TERMINATION, I_LATER_DIE_REV;
  logic [1:0]  I_WIDTH_CFG, O_CMD, O_WR_RISE_VALID, O_WR_FALL_VALID;
  logic        O_CMD_VALID, O_MODE_LOAD, O_OP_BUSY;
  logic        O_UNUSED_IO_BALL_O, O_UNUSED_IO_BALL_OE, O_UNUSED_IO_BALL_TERM;
  logic [21:0] O_ADDR, O_MODE_VALUE, exp_addr = 22'h0, exp_mode = 22'h0;
  logic [2:0]  O_BANK, exp_bank = 3'h0;
  logic [1:0]  exp_cmd = 2'h3;
  logic [35:0] O_WR_DATA_RISE, O_WR_DATA_FALL;
  logic [31:0] seed = 32'h620D;
  logic [63:0] t, u;
  int          failures = 0, samples_checked = 0;
  wire         main_clk, data_clk, cs_n, byte_mask;
  wire [1:0]   cmd;
  wire [21:0]  addr;
  wire [2:0]   bank;
  wire [35:0]  dq;

  ctl_model i_ctl (.o_main_clk(main_clk), .o_cs_n(cs_n), .o_cmd(cmd), .o_addr(addr), .o_bank(bank),
                   .o_data_clk(data_clk), .o_dq(dq), .o_byte_mask(byte_mask));

  ddr_mem_input_capture #(.OP_CYCLES(OPC)) i_dut (
    .I_CLK_SYS, .I_ARST_N, .I_MAIN_CLK_TRUE(main_clk), .I_WR_DATA_CLK_LO_LANE(data_clk),
    .I_WR_DATA_CLK_HI_LANE(data_clk),
    .I_CS_N(cs_n), .I_WE_N(cmd[1]), .I_REF_N(cmd[0]), .I_ADDR_IN(addr), .I_BANK_SELECT(bank),
    .I_DQ(dq), .I_WRITE_BYTE_MASK(byte_mask), .I_WIDTH_CFG, .I_ON_DIE_TERMINATION, .I_LATER_DIE_REV,
    .O_CMD_VALID, .O_CMD, .O_ADDR, .O_BANK, .O_MODE_LOAD, .O_MODE_VALUE, .O_OP_BUSY,
    .O_WR_DATA_RISE, .O_WR_DATA_FALL, .O_WR_RISE_VALID, .O_WR_FALL_VALID,
    .O_UNUSED_IO_BALL_O, .O_UNUSED_IO_BALL_OE, .O_UNUSED_IO_BALL_TERM);

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [17:0] lane0(input logic [17:0] d);
    return (I_WIDTH_CFG == 2'h0) ? (d & ddr_cap_pkg::KEEP_X9) : d;
  endfunction

  task automatic chk(input string n, input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wait_for(input int lim, ref int n, input bit cmd_side);
    n = 0;
    while (n < lim && (cmd_side ? O_CMD_VALID : |{O_WR_RISE_VALID, O_WR_FALL_VALID}) !== 1'h1) begin
      @(posedge I_CLK_SYS);
      #1 n++;
    end
  endtask

  // a deselected command must leave valid, cmd, bank, addr, mode value and busy alone while busy runs out
  task automatic do_cmd(input logic cs, input logic [1:0] c, input logic [21:0] a, input logic [2:0] b);
    int n;
    int busy;
    i_ctl.cmd({cs, c, a, b});
    wait_for(14, n, 1'b1);
    busy = 0;
    chk("cmd_valid", 36'(n < 14), 36'(!cs));
    if (!cs) begin
      {exp_cmd, exp_bank} = {c, b};
      if (c == 2'h0) exp_mode = a;
      else if (c[1]) exp_addr = a; // refresh carries no address
      chk("mode_load", 36'(O_MODE_LOAD), 36'(c == 2'h0));
    end
    chk("cmd", 36'(O_CMD), 36'(exp_cmd));
    chk("bank", 36'(O_BANK), 36'(exp_bank));
    chk("addr", 36'(O_ADDR), 36'(exp_addr));
    chk("mode", 36'(O_MODE_VALUE), 36'(exp_mode));
    repeat (12) begin
      busy += int'(O_OP_BUSY === 1'h1);
      @(posedge I_CLK_SYS);
      #1;
    end
    chk("busy", 36'(busy), 36'((!cs && c != 2'h0) ? OPC : 0));
  endtask

  task automatic beat(input logic [35:0] r, input logic [35:0] f, input logic [1:0] m);
    int n;
    logic x;
    x = (I_WIDTH_CFG == 2'h2);
    i_ctl.pair({r, f}, m);
    wait_for(16, n, 1'b0);
    chk("rise_valid", 36'(O_WR_RISE_VALID), 36'({x & ~m[1], ~m[1]}));
    chk("fall_valid", 36'(O_WR_FALL_VALID), 36'({x & ~m[0], ~m[0]}));
    if (m != 2'h3) begin
      chk("rise_lo", 36'(O_WR_DATA_RISE[17:0]), 36'(lane0(r[17:0])));
      chk("fall_lo", 36'(O_WR_DATA_FALL[17:0]), 36'(lane0(f[17:0])));
      if (x) chk("hi", {O_WR_DATA_RISE[35:18], O_WR_DATA_FALL[35:18]}, {r[35:18], f[35:18]});
    end
  endtask

  // -------------------------------------------------------------
  // clock, watchdog and sequence
  // -------------------------------------------------------------
  initial begin
    I_CLK_SYS = 1'h0;
    forever #2 I_CLK_SYS = ~I_CLK_SYS;
  end

  initial begin
    #200000;
    failures++;
    final_report();
  end

  initial begin
    {I_ARST_N, I_WIDTH_CFG, I_ON_DIE_TERMINATION, I_LATER_DIE_REV} = 5'h0;
    repeat (2) @(posedge I_CLK_SYS);
    @(posedge main_clk);
    @(negedge I_CLK_SYS) I_ARST_N = 1'h1;
    #1;
    chk("rst_cmd", 36'(O_CMD), 36'h3);
    chk("rst_out", 36'({O_CMD_VALID, O_OP_BUSY, O_WR_RISE_VALID}), 36'h0);
    repeat (3) @(posedge main_clk);
    do_cmd(1'h0, 2'h0, 22'h3FFFFF, 3'h7);
    do_cmd(1'h1, 2'h2, 22'h15555, 3'h2);
    for (int i = 0; i < 24; i++) begin
      t = {rnd(), rnd()};
      do_cmd(i > 3 && t[63:62] == 2'h0, i < 4 ? i[1:0] : t[61:60], t[21:0], t[24:22]);
    end
    for (int w = 0; w < 4; w++) begin
      @(negedge I_CLK_SYS) I_WIDTH_CFG = w[1:0];
      repeat (4) @(posedge I_CLK_SYS);
      for (int k = 0; k < 8; k++) begin
        t = {rnd(), rnd()};
        u = {rnd(), rnd()};
        beat(t[35:0], u[35:0], k == 0 ? 2'h3 : k == 1 ? 2'h2 : u[63:62] & u[61:60]);
      end
    end
    for (int k = 0; k < 4; k++) begin
      @(negedge I_CLK_SYS) {I_ON_DIE_TERMINATION, I_LATER_DIE_REV} = k[1:0];
      repeat (6) @(posedge I_CLK_SYS);
      #1;
      chk("term", 36'(O_UNUSED_IO_BALL_TERM), 36'(k == 2));
      chk("drive", 36'({O_UNUSED_IO_BALL_O, O_UNUSED_IO_BALL_OE}), 36'h0);
    end
    final_report();
  end
endmodule // ddr_mem_input_capture_bench

`default_nettype wire
